// ===== verilog/msp_pkg.sv
// package: constants and carrier types of the spi master/slave port
// Function
// - bytes travel most significant bit first
// - master starts; slave answers on miso meanwhile
// - soft select mode ignores pin, uses level bit
// - first-edge slave: select low writes collide
// - master and enable bits hold only while select high
// - master data write loads shifter, drives sck
// - byte end sets done flag, may interrupt
// - master done clears: status access, data read
// - done set blocks data writes until status read
// - slave takes sck in, data write preloads miso
// - slave done clears: status access, data access
// - polarity and phase pick the capture edge
// - sck idles at the polarity level
// - master seeing select low sets mode fault
// - mode fault drops enable and master bits
// - fault clears: status read, then control write
// - fault blocks enable and master set attempts
// - slave never raises mode fault itself
// - one enable gates shared request of flags
// - master mode drives sck and swaps data pins
package msp_pkg;
    // control register, one bit per field in this order (bit 7 first)
    typedef struct packed {
        logic irq_enable;
        logic port_enable;
        logic rate2;
        logic master_select;
        logic cpol;
        logic cpha;
        logic rate1;
        logic rate0;
    } msp_ctrl_t;

    // control/status register, bit 7 first
    typedef struct packed {
        logic       transfer_done_flag;
        logic       write_collision_flag;
        logic       overrun_flag;
        logic       mode_fault_flag;
        logic [1:0] reserved;
        logic       soft_select_mode;
        logic       soft_select_level;
    } msp_stat_t;

    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [7:0] DATA_RST  = 8'h00;
    localparam logic [2:0] LAST_BIT  = 3'h7;
    localparam logic [3:0] LAST_EDGE = 4'hF;
    // shortest sck half period in system clocks, doubled per rate step
    localparam logic [9:0] HALF_MIN  = 10'h004;
endpackage : msp_pkg

// ===== verilog/msp_slave_shift.sv
// slave shifter clocked by the incoming serial clock
`timescale 1ns/1ps
`default_nettype none
module msp_slave_shift (
    // link clock and frame
    input  wire logic       sck_i,
    input  wire logic       frame_clr_i,
    input  wire logic       reset_i,
    // timing mode
    input  wire logic       cpol_i,
    input  wire logic       cpha_i,
    // serial data
    input  wire logic       mosi_i,
    output logic            miso_o,
    // parallel side
    input  wire logic [7:0] tx_byte_i,
    output logic [7:0]      rx_byte_o,
    output logic            done_tgl_o
);
    logic       sclk;
    logic [2:0] cnt_ff;
    logic [2:0] ocnt_ff;
    logic [6:0] rx_sh_ff;

    // rising sclk is always the capture edge, whatever the mode
    assign sclk = sck_i ^ cpol_i ^ cpha_i;

    // bit counter, cleared while the frame is deselected
    always_ff @(posedge sclk or posedge frame_clr_i) begin
        if (frame_clr_i) begin
            cnt_ff <= 3'h0;
        end else begin
            cnt_ff <= cnt_ff + 3'h1;
        end
    end

    // receive shifter, msb arrives first
    always_ff @(posedge sclk) begin
        rx_sh_ff <= {rx_sh_ff[5:0], mosi_i};
    end

    // whole byte and toggle for the system side
    always_ff @(posedge sclk or posedge reset_i) begin
        if (reset_i) begin
            rx_byte_o  <= msp_pkg::DATA_RST;
            done_tgl_o <= 1'b0;
        end else if (cnt_ff == msp_pkg::LAST_BIT) begin
            rx_byte_o  <= {rx_sh_ff, mosi_i};
            done_tgl_o <= ~done_tgl_o;
        end
    end

    // output index follows on the launch edge; index 0 covers first-edge mode
    always_ff @(negedge sclk or posedge frame_clr_i) begin
        if (frame_clr_i) begin
            ocnt_ff <= 3'h0;
        end else begin
            ocnt_ff <= cnt_ff;
        end
    end

    // tx byte is held still by the system side while selected in first-edge mode only
    assign miso_o = tx_byte_i[msp_pkg::LAST_BIT - ocnt_ff];
endmodule : msp_slave_shift
`default_nettype wire

// ===== verilog/msp_port.sv
// spi master/slave port: registers, flags, master engine, slave crossing
`timescale 1ns/1ps
`default_nettype none
module msp_port (
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       reset_i,
    // cpu register strobes
    input  wire logic       ctrl_wr_i,
    input  wire logic       stat_wr_i,
    input  wire logic       stat_rd_i,
    input  wire logic       data_wr_i,
    input  wire logic       data_rd_i,
    input  wire logic [7:0] wdata_i,
    // register contents
    output logic [7:0]      control_register_o,
    output logic [7:0]      control_status_register_o,
    output logic [7:0]      data_register_o,
    output logic            irq_o,
    // serial clock pin
    input  wire logic       sck_i,
    output logic            sck_o,
    output logic            sck_oe_n_o,
    // data pins
    input  wire logic       mosi_i,
    output logic            mosi_o,
    output logic            mosi_oe_n_o,
    input  wire logic       miso_i,
    output logic            miso_o,
    output logic            miso_oe_n_o,
    // slave select pin
    input  wire logic       ss_n_i
);
    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_FINISH} msp_state_t;

    msp_pkg::msp_ctrl_t ctrl_ff;
    msp_pkg::msp_ctrl_t nxt_ctrl;
    msp_state_t         state_ff;
    logic [1:0] ss_sync_ff;
    logic [1:0] miso_sync_ff;
    logic [2:0] dtg_sync_ff;
    logic       done_ff, done_arm_ff, done_rdseen_ff;
    logic       ovr_ff, wcol_ff, wcol_arm_ff;
    logic       mode_fault_flag_ff, mode_fault_flag_arm_ff;
    logic       ssm_ff, ssi_ff;
    logic [7:0] data_ff;
    logic [7:0] tx_hold_ff;
    logic [7:0] tx_sh_ff;
    logic [7:0] rx_sh_ff;
    logic [9:0] tick_ff;
    logic [3:0] edge_ff;
    logic       sck_ff;
    logic       pe, ms, sel_n_sys, sel_n_link, frame_clr;
    logic       slave_pulse, byte_end, done_clr, wr_block, wr_try, busy;
    logic       collide, start, mode_fault_flag_evt, edge_tick, sample;
    logic [9:0] half;
    logic       slave_miso;
    logic [7:0] slave_rx;
    logic       slave_tgl;
    msp_pkg::msp_stat_t stat_wd;

    // half period in system clocks for a rate selection
    function automatic logic [9:0] half_cnt(input msp_pkg::msp_ctrl_t c);
        half_cnt = msp_pkg::HALF_MIN << {c.rate2, c.rate1, c.rate0};
    endfunction : half_cnt

    assign pe = ctrl_ff.port_enable;
    assign ms = ctrl_ff.master_select;

    // pin synchronisers; second stage is looked at, the toggle sync also compares its third
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            ss_sync_ff   <= 2'h3;
            miso_sync_ff <= 2'h0;
            dtg_sync_ff  <= 3'h0;
        end else begin
            ss_sync_ff   <= {ss_sync_ff[0], ss_n_i};
            miso_sync_ff <= {miso_sync_ff[0], miso_i};
            dtg_sync_ff  <= {dtg_sync_ff[1:0], slave_tgl};
        end
    end

    // internal select: level bit under soft mode, pin otherwise
    assign sel_n_sys  = ssm_ff ? ssi_ff : ss_sync_ff[1];
    assign sel_n_link = ssm_ff ? ssi_ff : ss_n_i;
    // fault only as master, and only from the internal level
    assign mode_fault_flag_evt   = pe & ms & ~sel_n_sys;

    // event and sequence terms
    assign slave_pulse = (dtg_sync_ff[2] ^ dtg_sync_ff[1]) & ~ms;
    assign byte_end    = (state_ff == ST_FINISH) | slave_pulse;
    assign done_clr    = done_arm_ff & (data_rd_i | (~ms & data_wr_i));
    assign wr_block    = done_ff & ~done_rdseen_ff;
    assign wr_try      = data_wr_i & ~wr_block;
    // first-edge slave cannot reload while selected
    assign busy        = pe & (ms ? (state_ff != ST_IDLE) : (~ctrl_ff.cpha & ~sel_n_sys));
    assign collide     = wr_try & busy;
    assign start       = wr_try & ~busy & pe & ms;

    // control register; write refused for port enable and master bits during a fault
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (ctrl_wr_i) begin
            nxt_ctrl = msp_pkg::msp_ctrl_t'(wdata_i);
            if (mode_fault_flag_ff && !mode_fault_flag_arm_ff) begin
                nxt_ctrl.port_enable   = 1'b0;
                nxt_ctrl.master_select = 1'b0;
            end
        end
        if (mode_fault_flag_evt) begin
            nxt_ctrl.port_enable   = 1'b0;
            nxt_ctrl.master_select = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            ctrl_ff <= msp_pkg::msp_ctrl_t'(msp_pkg::CTRL_RST);
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // select management bits; write data viewed through the status layout
    assign stat_wd = msp_pkg::msp_stat_t'(wdata_i);
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            ssm_ff <= 1'b0;
            ssi_ff <= 1'b0;
        end else if (stat_wr_i) begin
            ssm_ff <= stat_wd.soft_select_mode;
            ssi_ff <= stat_wd.soft_select_level;
        end
    end

    // transfer done flag and its two-step clear; a new byte wins
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            done_ff        <= 1'b0;
            done_arm_ff    <= 1'b0;
            done_rdseen_ff <= 1'b0;
        end else begin
            if (byte_end) begin
                done_ff <= 1'b1;
            end else if (done_clr) begin
                done_ff <= 1'b0;
            end
            if (done_clr || !done_ff) begin
                done_arm_ff <= 1'b0;
            end else if (stat_rd_i || stat_wr_i) begin
                done_arm_ff <= 1'b1;
            end
            if (done_clr || !done_ff) begin
                done_rdseen_ff <= 1'b0;
            end else if (stat_rd_i) begin
                done_rdseen_ff <= 1'b1;
            end
        end
    end

    // overrun: a byte ends while the previous one is unacknowledged
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            ovr_ff <= 1'b0;
        end else if (byte_end && done_ff && !done_clr) begin
            ovr_ff <= 1'b1;
        end else if (stat_rd_i) begin
            ovr_ff <= 1'b0;
        end
    end

    // write collision: status read, then any data access, clears it
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            wcol_ff     <= 1'b0;
            wcol_arm_ff <= 1'b0;
        end else begin
            if (collide) begin
                wcol_ff <= 1'b1;
            end else if (wcol_arm_ff && (data_rd_i || data_wr_i)) begin
                wcol_ff <= 1'b0;
            end
            if (!wcol_ff) begin
                wcol_arm_ff <= 1'b0;
            end else if (stat_rd_i) begin
                wcol_arm_ff <= 1'b1;
            end
        end
    end

    // mode fault flag; stays set after falling back to slave
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            mode_fault_flag_ff     <= 1'b0;
            mode_fault_flag_arm_ff <= 1'b0;
        end else begin
            if (mode_fault_flag_evt) begin
                mode_fault_flag_ff <= 1'b1;
            end else if (mode_fault_flag_arm_ff && ctrl_wr_i) begin
                mode_fault_flag_ff <= 1'b0;
            end
            if (!mode_fault_flag_ff) begin
                mode_fault_flag_arm_ff <= 1'b0;
            end else if (stat_rd_i) begin
                mode_fault_flag_arm_ff <= 1'b1;
            end
        end
    end

    // receive buffer keeps the first byte after the last clear
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            data_ff <= msp_pkg::DATA_RST;
        end else if (byte_end && !(done_ff && !done_clr)) begin
            data_ff <= ms ? rx_sh_ff : slave_rx;
        end
    end

    // slave transmit byte, held still while selected in first-edge mode
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            tx_hold_ff <= msp_pkg::DATA_RST;
        end else if (wr_try && !busy && !ms) begin
            tx_hold_ff <= wdata_i;
        end
    end

    // master engine: 16 sck edges, an edge every half period
    assign half      = half_cnt(ctrl_ff);
    assign edge_tick = (state_ff == ST_SHIFT) && (tick_ff == half - 10'h001);
    // even edges lead; capture on leading edge when cpha is 0
    assign sample    = (edge_ff[0] == ctrl_ff.cpha);

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_ff <= ST_IDLE;
            tick_ff  <= 10'h000;
            edge_ff  <= 4'h0;
            sck_ff   <= 1'b0;
        end else if (!pe || !ms) begin
            // a fault or disable aborts the byte at once
            state_ff <= ST_IDLE;
            tick_ff  <= 10'h000;
            edge_ff  <= 4'h0;
            sck_ff   <= ctrl_ff.cpol;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    sck_ff  <= ctrl_ff.cpol;
                    tick_ff <= 10'h000;
                    edge_ff <= 4'h0;
                    if (start) begin
                        state_ff <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (edge_tick) begin
                        tick_ff <= 10'h000;
                        sck_ff  <= ~sck_ff;
                        edge_ff <= edge_ff + 4'h1;
                        if (edge_ff == msp_pkg::LAST_EDGE) begin
                            state_ff <= ST_FINISH;
                        end
                    end else begin
                        tick_ff <= tick_ff + 10'h001;
                    end
                end
                ST_FINISH: begin
                    state_ff <= ST_IDLE;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // master shifters; second-edge mode keeps bit 7 for the first edge
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            tx_sh_ff <= msp_pkg::DATA_RST;
            rx_sh_ff <= msp_pkg::DATA_RST;
        end else begin
            if (start) begin
                tx_sh_ff <= wdata_i;
            end else if (edge_tick && !sample && !(ctrl_ff.cpha && edge_ff == 4'h0)) begin
                tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
            end
            if (edge_tick && sample) begin
                rx_sh_ff <= {rx_sh_ff[6:0], miso_sync_ff[1]};
            end
        end
    end

    // slave side on the link clock; deselect or master mode ends the frame
    assign frame_clr = sel_n_link | ~pe | ms;

    msp_slave_shift u_slave (
        .sck_i       (sck_i),
        .frame_clr_i (frame_clr),
        .reset_i     (reset_i),
        .cpol_i      (ctrl_ff.cpol),
        .cpha_i      (ctrl_ff.cpha),
        .mosi_i      (mosi_i),
        .miso_o      (slave_miso),
        .tx_byte_i   (tx_hold_ff),
        .rx_byte_o   (slave_rx),
        .done_tgl_o  (slave_tgl)
    );

    // pin roles swap with master mode; disabled port releases all pins
    assign sck_o       = sck_ff;
    assign sck_oe_n_o  = ~(pe & ms);
    assign mosi_o      = tx_sh_ff[7];
    assign mosi_oe_n_o = ~(pe & ms);
    assign miso_o      = slave_miso;
    assign miso_oe_n_o = ~(pe & ~ms & ~sel_n_sys);

    // register views and the shared request line
    assign control_register_o        = ctrl_ff;
    assign control_status_register_o = {done_ff, wcol_ff, ovr_ff, mode_fault_flag_ff, 2'h0, ssm_ff, ssi_ff};
    assign data_register_o           = data_ff;
    assign irq_o = ctrl_ff.irq_enable & (done_ff | mode_fault_flag_ff | ovr_ff);

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_done_ack;
        done_ff && stat_rd_i && !byte_end ##1 data_rd_i && ms && !byte_end;
    endsequence

    sequence s_fast_start;
        start && half == 10'h004;
    endsequence

    mode_fault_set_a: assert property (mode_fault_flag_evt |=> mode_fault_flag_ff)
        else $error("mode fault not flagged");
    fault_drops_bits_a: assert property (mode_fault_flag_evt |=> !pe && !ms)
        else $error("mode fault left enable or master set");
    fault_refuses_set_a: assert property (mode_fault_flag_ff && !mode_fault_flag_arm_ff && ctrl_wr_i |=> !pe && !ms)
        else $error("enable set during mode fault");
    slave_no_fault_a: assert property (!ms && !mode_fault_flag_ff |=> !mode_fault_flag_ff)
        else $error("mode fault raised in slave mode");
    done_clear_seq_a: assert property (s_done_ack |=> !done_ff)
        else $error("done flag not cleared by sequence");
    write_inhibit_a: assert property (wr_block && data_wr_i && state_ff == ST_IDLE |=> state_ff == ST_IDLE)
        else $error("data write accepted while done flag blocks it");
    byte_length_a: assert property (s_fast_start |-> ##1 state_ff == ST_SHIFT ##64 state_ff == ST_FINISH)
        else $error("master byte does not last sixteen half periods");
    idle_level_a: assert property (state_ff == ST_IDLE && pe && ms ##1 state_ff == ST_IDLE |-> sck_o == $past(ctrl_ff.cpol))
        else $error("sck idle level differs from polarity");
    overrun_set_a: assert property (byte_end && done_ff && !done_clr |=> ovr_ff)
        else $error("overrun not flagged");
endmodule : msp_port
`default_nettype wire

// ===== dv/msp_far_end.sv
// far side model: external spi slave or master facing the port
`timescale 1ns/1ps
`default_nettype none
module msp_far_end (
    // link clock and timing mode
    input  wire logic       link_clk_i,
    input  wire logic       cpol_i,
    input  wire logic       cpha_i,
    // resolved pins
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    input  wire logic       miso_i,
    // slave role control
    input  wire logic       slv_sel_i,
    input  wire logic [7:0] slv_tx_i,
    output logic [7:0]      slv_rx_o,
    // far side drivers
    output logic            sck_o,
    output logic            mosi_o,
    output logic            miso_o,
    output logic            ss_n_o
);
    logic [7:0] sreg_q = 8'h00;
    logic [7:0] rx_q   = 8'h00;
    logic       miso_q = 1'b0;
    logic       sck_q  = 1'b0;
    logic       mosi_q = 1'b0;
    logic       ss_q   = 1'b1;
    logic       frame_q = 1'b0;

    // sck stands at the pulled polarity level outside frames
    assign sck_o    = frame_q ? sck_q : cpol_i;
    // released lines show the inverse of their last value, never a kind copy
    assign mosi_o   = frame_q ? mosi_q : ~mosi_q;
    assign miso_o   = slv_sel_i ? miso_q : ~miso_q;
    assign ss_n_o   = ss_q;
    assign slv_rx_o = rx_q;

    // slave role: first-edge mode must show bit 7 before any clock edge
    always @(posedge slv_sel_i) begin
        sreg_q = slv_tx_i;
        if (!cpha_i) begin
            miso_q = sreg_q[7];
            sreg_q = {sreg_q[6:0], 1'b0};
        end
    end

    // slave role: capture on leading edge for cpha 0, trailing for cpha 1
    always @(sck_i) begin
        if (slv_sel_i && ((sck_i != cpol_i) ^ cpha_i)) begin
            rx_q = {rx_q[6:0], mosi_i};
        end else if (slv_sel_i) begin
            miso_q = sreg_q[7];
            sreg_q = {sreg_q[6:0], 1'b0};
        end
    end

    // master role: one byte over sixteen link clock edges, msb first
    task automatic send_byte(input logic [7:0] tx, input logic use_pin, output logic [7:0] rx);
        int i;
        int b;
        rx = 8'h00;
        b = cpha_i ? 0 : 1;
        @(posedge link_clk_i);
        ss_q = ~use_pin;
        sck_q = cpol_i;
        mosi_q = tx[7];
        frame_q = 1'b1;
        // select setup: the port's select synchroniser needs a few system clocks
        repeat (8) @(posedge link_clk_i);
        for (i = 0; i < 16; i++) begin
            @(link_clk_i);
            if (((i % 2) == 0) != cpha_i) begin
                rx = {rx[6:0], miso_i};
                sck_q = ~sck_q;
            end else begin
                sck_q = ~sck_q;
                mosi_q = (b < 8) ? tx[7 - b] : ~mosi_q;
                b++;
            end
        end
        repeat (4) @(posedge link_clk_i);
        ss_q = 1'b1;
        frame_q = 1'b0;
    endtask : send_byte
endmodule : msp_far_end
`default_nettype wire

// ===== dv/msp_port_tb.sv
// testbench: strobe-level tests of the spi port against the far side model
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module msp_port_tb;
    logic       sys_clk  = 1'b0;
    logic       link_clk = 1'b0;
    logic       reset    = 1'b1;
    logic [4:0] stb      = 5'h00;
    logic [7:0] wdata    = 8'h00;
    logic       flt_ss_n = 1'b1;
    logic       cpol     = 1'b0;
    logic       cpha     = 1'b0;
    logic       slv_sel  = 1'b0;
    logic [7:0] slv_tx   = 8'h00;
    logic [7:0] slv_rx, rxb, ctrl_q, stat_q, data_q;
    logic       irq, sck_d, sck_oe_n, mosi_d, mosi_oe_n, miso_d, miso_oe_n;
    logic       f_sck, f_mosi, f_miso, f_ss_n;
    wire logic  sck_w, mosi_w, miso_w;
    int         err_total = 0;
    int         tests_run = 0;

    // each pin follows whichever party has its driver on
    assign sck_w  = sck_oe_n ? f_sck : sck_d;
    assign mosi_w = mosi_oe_n ? f_mosi : mosi_d;
    assign miso_w = miso_oe_n ? f_miso : miso_d;

    // clocks: link clock offset so the two never share edges
    initial forever #12.5 sys_clk = ~sys_clk;
    initial begin
        #3.7;
        forever #6 link_clk = ~link_clk;
    end

    msp_port dut_u (.sys_clk_i(sys_clk), .reset_i(reset), .ctrl_wr_i(stb[0]),
        .stat_wr_i(stb[1]), .stat_rd_i(stb[2]), .data_wr_i(stb[3]), .data_rd_i(stb[4]),
        .wdata_i(wdata), .control_register_o(ctrl_q), .control_status_register_o(stat_q),
        .data_register_o(data_q), .irq_o(irq), .sck_i(sck_w), .sck_o(sck_d),
        .sck_oe_n_o(sck_oe_n), .mosi_i(mosi_w), .mosi_o(mosi_d), .mosi_oe_n_o(mosi_oe_n),
        .miso_i(miso_w), .miso_o(miso_d), .miso_oe_n_o(miso_oe_n),
        .ss_n_i(f_ss_n & flt_ss_n));
    msp_far_end far_u (.link_clk_i(link_clk), .cpol_i(cpol), .cpha_i(cpha), .sck_i(sck_w),
        .mosi_i(mosi_w), .miso_i(miso_w), .slv_sel_i(slv_sel), .slv_tx_i(slv_tx),
        .slv_rx_o(slv_rx), .sck_o(f_sck), .mosi_o(f_mosi), .miso_o(f_miso), .ss_n_o(f_ss_n));

    function automatic logic [7:0] cw(input logic ie, pe, ms, pol, pha);
        return {ie, pe, 1'b0, ms, pol, pha, 2'b00};
    endfunction : cw

    // strobe k: 0 ctrl write, 1 status write, 2 status read, 3 data write, 4 data read
    task automatic pulse(input int k, input logic [7:0] d);
        @(negedge sys_clk);
        wdata = d;
        stb[k] = 1'b1;
        @(negedge sys_clk);
        stb = 5'h00;
    endtask : pulse

    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : idle

    task automatic wait_stat(input int b, input logic v);
        for (int n = 0; n < 400; n++) begin
            @(negedge sys_clk);
            if (stat_q[b] === v) break;
        end
        `CHK(stat_q[b], v)
    endtask : wait_stat

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude

    // watchdog: whole run is a few hundred cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        conclude();
    end

    initial begin : main_seq
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        // master byte in all four timing modes
        for (int m = 0; m < 4; m++) begin
            cpol = m[1];
            cpha = m[0];
            pulse(0, cw(1, 0, 0, cpol, cpha));
            pulse(1, 8'h03);
            pulse(0, cw(1, 1, 1, cpol, cpha));
            `CHK(sck_w, cpol)
            `CHK({sck_oe_n, mosi_oe_n, miso_oe_n}, 3'b001)
            slv_tx = 8'hA5 ^ 8'(m);
            slv_sel = 1'b1;
            pulse(3, 8'(8'h3C + m));
            wait_stat(7, 1'b1);
            `CHK(irq, 1'b1)
            `CHK(slv_rx, 8'(8'h3C + m))
            `CHK(data_q, 8'hA5 ^ 8'(m))
            slv_sel = 1'b0;
            pulse(3, 8'hFF);
            idle(6);
            `CHK(sck_w, cpol)
            `CHK(stat_q[6], 1'b0)
            pulse(4, 8'h00);
            `CHK(stat_q[7], 1'b1)
            pulse(2, 8'h00);
            pulse(4, 8'h00);
            idle(1);
            `CHK(stat_q[7], 1'b0)
            `CHK(irq, 1'b0)
        end
        $display("test master modes done");
        // slave byte in all four modes, both clearing sequences
        for (int m = 0; m < 4; m++) begin
            cpol = m[1];
            cpha = m[0];
            pulse(0, cw(1, 0, 0, cpol, cpha));
            pulse(1, cpha ? 8'h02 : 8'h00);
            pulse(0, cw(1, 1, 0, cpol, cpha));
            idle(3);
            `CHK({sck_oe_n, mosi_oe_n, miso_oe_n}, {2'b11, ~cpha})
            pulse(3, 8'h96 ^ 8'(m));
            far_u.send_byte(8'(8'h5A + m), ~cpha, rxb);
            wait_stat(7, 1'b1);
            `CHK(rxb, 8'h96 ^ 8'(m))
            `CHK(data_q, 8'(8'h5A + m))
            `CHK(stat_q[4], 1'b0)
            pulse(2, 8'h00);
            pulse(cpha ? 3 : 4, 8'h11);
            idle(1);
            `CHK(stat_q[7], 1'b0)
        end
        // second-edge slave: two bytes without clearing done overrun
        far_u.send_byte(8'hC3, 1'b0, rxb);
        wait_stat(7, 1'b1);
        far_u.send_byte(8'h3C, 1'b0, rxb);
        idle(8);
        `CHK(stat_q[5], 1'b1)
        `CHK(data_q, 8'hC3)
        pulse(2, 8'h00);
        pulse(4, 8'h00);
        idle(1);
        `CHK(stat_q[7:5], 3'b000)
        // first-edge slave held selected: a data write collides
        cpol = 1'b0;
        cpha = 1'b0;
        pulse(0, cw(0, 0, 0, 0, 0));
        pulse(1, 8'h00);
        pulse(0, cw(0, 1, 0, 0, 0));
        flt_ss_n = 1'b0;
        idle(4);
        pulse(3, 8'h77);
        `CHK(stat_q[6], 1'b1)
        flt_ss_n = 1'b1;
        pulse(2, 8'h00);
        pulse(4, 8'h00);
        idle(1);
        `CHK(stat_q[6], 1'b0)
        $display("test slave modes done");
        // mode fault: soft level hides the pin, then pin select trips it
        pulse(0, cw(1, 0, 0, 0, 0));
        pulse(1, 8'h03);
        pulse(0, cw(1, 1, 1, 0, 0));
        flt_ss_n = 1'b0;
        idle(6);
        `CHK(stat_q[4], 1'b0)
        `CHK({ctrl_q[6], ctrl_q[4]}, 2'b11)
        flt_ss_n = 1'b1;
        idle(4);
        pulse(1, 8'h00);
        flt_ss_n = 1'b0;
        wait_stat(4, 1'b1);
        `CHK(irq, 1'b1)
        `CHK({ctrl_q[6], ctrl_q[4]}, 2'b00)
        `CHK({sck_oe_n, mosi_oe_n, miso_oe_n}, 3'b111)
        flt_ss_n = 1'b1;
        idle(4);
        pulse(0, cw(1, 1, 1, 0, 0));
        `CHK({ctrl_q[6], ctrl_q[4]}, 2'b00)
        `CHK(stat_q[4], 1'b1)
        pulse(2, 8'h00);
        pulse(0, cw(0, 1, 1, 0, 0));
        idle(1);
        `CHK(stat_q[4], 1'b0)
        `CHK({ctrl_q[6], ctrl_q[4]}, 2'b11)
        `CHK(irq, 1'b0)
        $display("test mode fault done");
        conclude();
    end
endmodule : msp_port_tb
`default_nettype wire
